// file: verilog/atm_pkg.sv
// Purpose: Constants for the converter trigger mode control block
// Assumes: APB slave with 32-bit data, byte addresses
// Notes: Register offsets are local choices
package atm_pkg;
    localparam int ATM_NUM_CONV = 5;
    localparam int ATM_NUM_INPUTS = 12;
    localparam logic [7:0] ATM_OFS_MODE = 8'h00;
    localparam logic [7:0] ATM_OFS_SNS = 8'h04;
    localparam logic [7:0] ATM_OFS_SCAN = 8'h08;
    localparam int ATM_SEL_LSB = 16;
    localparam int ATM_PRESYNC_LSB = 8;
    localparam int ATM_SAMPLE_LSB = 0;
    localparam logic [31:0] ATM_MODE_MASK = 32'h03ff_1f1f;
    localparam logic [31:0] ATM_SNS_MASK = 32'h0000_0fff;
    localparam logic [31:0] ATM_SCAN_MASK = 32'h0000_0001;
    localparam logic [1:0] ATM_SEL_PRIMARY = 2'h0;
    localparam logic [1:0] ATM_SEL_ALTERNATE = 2'h1;
    localparam logic [31:0] ATM_RESET_VALUE = 32'h0000_0000;
endpackage

// file: verilog/atm_trigger_mode.sv
// Purpose: Trigger mode configuration and trigger qualification for the converters
// Assumes: Trigger inputs are asynchronous and pass two flip-flops
// Notes: Zero wait-state APB slave; unmapped reads return zero, pslverr low
`timescale 1ns/1ps
module atm_trigger_mode #(
    parameter int NUM_CONV = atm_pkg::ATM_NUM_CONV,
    parameter int NUM_INPUTS = atm_pkg::ATM_NUM_INPUTS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_INPUTS-1:0] input_trigger,
    input wire logic scan_trigger,
    output logic [NUM_INPUTS-1:0] input_trigger_fire,
    output logic scan_trigger_fire,
    output logic [NUM_CONV-1:0] conv_use_alternate,
    output logic [NUM_CONV-1:0] conv_presync_trigger_en,
    output logic [NUM_CONV-1:0] conv_sample_en
);
    import atm_pkg::*;

    // ****************************************
    // Register file
    // ****************************************
    logic [31:0] trigger_mode_config;
    logic [31:0] trigger_sensitivity_config;
    logic scan_trigger_sensitivity;
    logic wr_en;
    logic rd_setup;
    logic wr_mode;
    logic wr_sns;
    logic wr_scan;
    logic [31:0] next_prdata;

    // Register picked by an address
    typedef enum logic [1:0] {
        REG_MODE = 2'b00,
        REG_SNS = 2'b01,
        REG_SCAN = 2'b10,
        REG_NONE = 2'b11
    } atm_reg_sel_t;

    // Shared by the write and read paths
    function automatic atm_reg_sel_t decode_addr(input logic [7:0] addr);
        atm_reg_sel_t sel;
        sel = REG_NONE;
        if (addr == ATM_OFS_MODE) begin
            sel = REG_MODE;
        end
        if (addr == ATM_OFS_SNS) begin
            sel = REG_SNS;
        end
        if (addr == ATM_OFS_SCAN) begin
            sel = REG_SCAN;
        end
        return sel;
    endfunction

    // Reserved codes fall back to the primary input
    function automatic logic sel_is_alternate(input logic [1:0] code);
        return code == ATM_SEL_ALTERNATE;
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_mode = wr_en && (decode_addr(paddr) == REG_MODE);
    assign wr_sns = wr_en && (decode_addr(paddr) == REG_SNS);
    assign wr_scan = wr_en && (decode_addr(paddr) == REG_SCAN);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_mode_config <= ATM_RESET_VALUE;
        end else if (wr_mode) begin
            trigger_mode_config <= pwdata & ATM_MODE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_sensitivity_config <= ATM_RESET_VALUE;
        end else if (wr_sns) begin
            trigger_sensitivity_config <= pwdata & ATM_SNS_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_trigger_sensitivity <= 1'b0;
        end else if (wr_scan) begin
            scan_trigger_sensitivity <= pwdata[0];
        end
    end

    // Unmapped reads return zero
    always_comb begin
        unique case (decode_addr(paddr))
            REG_MODE: next_prdata = trigger_mode_config;
            REG_SNS: next_prdata = trigger_sensitivity_config;
            REG_SCAN: next_prdata = {31'h0000_0000, scan_trigger_sensitivity};
            REG_NONE: next_prdata = ATM_RESET_VALUE;
        endcase
    end

    // Taken in the setup phase, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ATM_RESET_VALUE;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

    // ****************************************
    // Converter configuration outputs
    // ****************************************
    // Decoded at write time so the output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_use_alternate <= '0;
        end else if (wr_mode) begin
            for (int c = 0; c < NUM_CONV; c++) begin
                conv_use_alternate[c] <=
                    sel_is_alternate(pwdata[ATM_SEL_LSB+2*c +: 2]);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++) begin : g_conv
            assign conv_presync_trigger_en[g] =
                trigger_mode_config[ATM_PRESYNC_LSB+g];
            assign conv_sample_en[g] = trigger_mode_config[ATM_SAMPLE_LSB+g];
        end
    endgenerate

    // ****************************************
    // Trigger synchronisers and qualification
    // ****************************************
    logic [NUM_INPUTS:0] trig_meta;
    logic [NUM_INPUTS:0] trig_sync;
    logic [NUM_INPUTS:0] trig_prev;
    logic [NUM_INPUTS:0] level_mode;

    assign level_mode = {scan_trigger_sensitivity,
        trigger_sensitivity_config[NUM_INPUTS-1:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_meta <= '0;
            trig_sync <= '0;
            trig_prev <= '0;
        end else begin
            trig_meta <= {scan_trigger, input_trigger};
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    logic [NUM_INPUTS:0] next_fire;
    always_comb begin
        // Level repeats every cycle, edge fires once
        next_fire = (level_mode & trig_sync) |
            (~level_mode & trig_sync & ~trig_prev);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_trigger_fire <= '0;
            scan_trigger_fire <= 1'b0;
        end else begin
            input_trigger_fire <= next_fire[NUM_INPUTS-1:0];
            scan_trigger_fire <= next_fire[NUM_INPUTS];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    mode_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (trigger_mode_config & ~ATM_MODE_MASK) == 32'h0)
        else $error("mode reserved bits set");
    sns_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (trigger_sensitivity_config & ~ATM_SNS_MASK) == 32'h0)
        else $error("sensitivity reserved bits set");
    mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ATM_OFS_MODE |=> trigger_mode_config == ($past(pwdata) & ATM_MODE_MASK))
        else $error("mode write lost");
    alt_sel4_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_use_alternate[4] == (trigger_mode_config[25:24] == 2'h1))
        else $error("conv4 select wrong");
    alt_sel3_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_use_alternate[3] == (trigger_mode_config[23:22] == 2'h1))
        else $error("conv3 select wrong");
    alt_sel2_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_use_alternate[2] == (trigger_mode_config[21:20] == 2'h1))
        else $error("conv2 select wrong");
    alt_sel1_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_use_alternate[1] == (trigger_mode_config[19:18] == 2'h1))
        else $error("conv1 select wrong");
    alt_sel0_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_use_alternate[0] == (trigger_mode_config[17:16] == 2'h1))
        else $error("conv0 select wrong");
    presync_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_presync_trigger_en == trigger_mode_config[12:8])
        else $error("presync map wrong");
    level_retrig_a: assert property (@(posedge pclk) disable iff (!presetn)
        trigger_sensitivity_config[0] && trig_sync[0] [*2] |=> input_trigger_fire[0])
        else $error("level trigger not repeated");
    edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        !trigger_sensitivity_config[0] && trig_sync[0] && trig_prev[0] |=> !input_trigger_fire[0])
        else $error("edge trigger repeated");
    scan_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        scan_trigger_sensitivity && trig_sync[NUM_INPUTS] |=> scan_trigger_fire)
        else $error("scan level trigger missed");

    // Register storage, readback and sample enable map
    sns_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ATM_OFS_SNS |=>
            trigger_sensitivity_config == ($past(pwdata) & ATM_SNS_MASK))
        else $error("sensitivity write lost");
    scan_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ATM_OFS_SCAN |=> scan_trigger_sensitivity == $past(pwdata[0]))
        else $error("scan sensitivity write lost");
    mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == ATM_OFS_MODE) |=> $stable(trigger_mode_config))
        else $error("mode register changed unasked");
    sns_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == ATM_OFS_SNS) |=> $stable(trigger_sensitivity_config))
        else $error("sensitivity register changed unasked");
    scan_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == ATM_OFS_SCAN) |=> $stable(scan_trigger_sensitivity))
        else $error("scan sensitivity changed unasked");
    alt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == ATM_OFS_MODE) |=> $stable(conv_use_alternate))
        else $error("input select changed unasked");
    mode_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == ATM_OFS_MODE |=>
            prdata == $past(trigger_mode_config))
        else $error("mode readback wrong");
    sns_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == ATM_OFS_SNS |=>
            prdata == $past(trigger_sensitivity_config))
        else $error("sensitivity readback wrong");
    scan_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == ATM_OFS_SCAN |=>
            prdata == {31'h0000_0000, $past(scan_trigger_sensitivity)})
        else $error("scan sensitivity readback wrong");
    unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr != ATM_OFS_MODE && paddr != ATM_OFS_SNS &&
            paddr != ATM_OFS_SCAN |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside setup");
    sample_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_sample_en == trigger_mode_config[4:0])
        else $error("sample enable map wrong");

    // ****************************************
    // Per-input trigger checks
    // ****************************************
    logic [NUM_INPUTS:0] fire_seen;

    // Scan trigger rides in the top bit
    assign fire_seen = {scan_trigger_fire, input_trigger_fire};
    genvar n;
    generate
        for (n = 0; n <= NUM_INPUTS; n++) begin : g_trig_chk
            level_each_a: assert property (@(posedge pclk) disable iff (!presetn)
                level_mode[n] && trig_sync[n] |=> fire_seen[n])
                else $error("level trigger missed");
            edge_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
                !level_mode[n] && trig_sync[n] && !trig_prev[n] |=> fire_seen[n])
                else $error("edge trigger missed");
            edge_single_a: assert property (@(posedge pclk) disable iff (!presetn)
                !level_mode[n] && trig_prev[n] |=> !fire_seen[n])
                else $error("edge trigger fired twice");
            idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
                !trig_sync[n] |=> !fire_seen[n])
                else $error("trigger fired while idle");
        end
    endgenerate
endmodule

// file: verif/atm_trig_src.sv
// Purpose: Trigger source model facing the trigger mode block
// Assumes: Sources change just after a rising clock edge
// Notes: Levels follow the bench request for whole clock periods
`timescale 1ns/1ps
module atm_trig_src (
    input wire logic pclk,
    input wire logic [12:0] want,
    output logic [11:0] input_trigger = '0,
    output logic scan_trigger = 1'b0
);
    // Launch requested levels on the rising edge only
    always @(posedge pclk) begin
        {input_trigger, scan_trigger} <= want;
    end
endmodule

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the trigger mode block
// Assumes: APB master waits on pready; trigger sources in a model
// Notes: Register contents mirrored in a bench model
`timescale 1ns/1ps
module tb_top;
    import atm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, scan_trigger, scan_fire, err;
    logic [12:0] want = '0;
    logic [11:0] input_trigger, fire, m;
    logic [4:0] alt, pre, smp;
    logic [14:0] ex;
    logic [31:0] mdl[3] = '{0, 0, 0};
    logic [31:0] msk[3] = '{ATM_MODE_MASK, ATM_SNS_MASK, ATM_SCAN_MASK};
    int bad_count = 0, n_checks = 0, cnt, xtra;
    initial forever #10 pclk = ~pclk;
    atm_trig_src i_src (.pclk(pclk), .want(want), .input_trigger(input_trigger),
        .scan_trigger(scan_trigger));
    atm_trigger_mode i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .input_trigger(input_trigger), .scan_trigger(scan_trigger),
        .input_trigger_fire(fire), .scan_trigger_fire(scan_fire), .conv_use_alternate(alt),
        .conv_presync_trigger_en(pre), .conv_sample_en(smp));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        if (w && a < 8'h0c) mdl[a[3:2]] = d & msk[a[3:2]];
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [4:0] alt_of(input logic [31:0] r);
        for (int i = 0; i < 5; i++)
            alt_of[i] = (r[16 + 2 * i +: 2] == ATM_SEL_ALTERNATE);
    endfunction
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        print_verdict();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(32'h25d5));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({4'h0, fire, scan_fire, alt, pre, smp}, 32'h0);
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, err}, 32'h0);
        end
        repeat (12) for (int a = 0; a < 16; a += 4) begin
            apb(1'b1, a[7:0], $urandom);
            apb(1'b0, a[7:0], 32'h0);
            chk(rd, (a < 12) ? mdl[a / 4] : 32'h0);
            @(negedge pclk);
            ex = {alt_of(mdl[0]), mdl[0][12:8], mdl[0][4:0]};
            chk({17'h0, alt, pre, smp}, {17'h0, ex});
        end
        for (int k = 0; k < 2; k++) begin
            m = 12'($urandom) | 12'h1;
            apb(1'b1, ATM_OFS_SNS, k ? 32'hfff : 32'h0);
            apb(1'b1, ATM_OFS_SCAN, k);
            {cnt, xtra} = 0;
            @(posedge pclk);
            want <= {m, 1'b1};
            for (int t = 0; t < 16; t++) begin
                @(negedge pclk);
                if (t == 10) want <= '0;
                cnt += ({fire, scan_fire} === {m, 1'b1});
                xtra += (({fire, scan_fire} & ~{m, 1'b1}) != 0);
            end
            chk(cnt, k ? 10 : 1);
            chk(xtra, 0);
        end
        print_verdict();
    end
endmodule
